// [verilog/pin_mux_defs.svh]
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define NPIN        66
`define NSET_M      9
`define NSET_C      3
`define NFN_M       15
`define NPRI_M      11
`define NFN_C       3
`define NTRIP       12
`define NXINT       3
`define QUAL_DEPTH  6
// ----------------------------------------
// Master word offsets (byte = word*4)
// ----------------------------------------
`define M_SET_SHIFT 4
`define M_DATA      4'h0
`define M_DIR       4'h1
`define M_AFSEL     4'h2
`define M_PUR       4'h3
`define M_PCTL      4'h4
`define M_APSEL     4'h5
`define M_IM        4'h6
`define M_RIS       4'h7
`define M_MIS       4'h8
`define M_AMSEL_W   8'h90
// ----------------------------------------
// Control word offsets
// ----------------------------------------
`define C_MUX_LOW   3'h0
`define C_MUX_HIGH  3'h1
`define C_DIR       3'h2
`define C_DAT       3'h3
`define C_CLAIM     3'h4
`define C_GPI       3'h5
`define C_QUAL      3'h6
`define C_TRIP_W    8'h20
`define C_XINT_W    8'h2c
`define C_WAKE_W    8'h2f
`define C_QPER_W    8'h30
// ----------------------------------------
// Analog pins, clock pin, excluded sources
// ----------------------------------------
`define USB_VBUS    7'd38
`define USB_DM      7'd42
`define USB_DP      7'd45
`define USB_ID      7'd46
`define AUX_CLK_PIN 7'd63
`define NO_SRC_A    6'd39
`define NO_SRC_B    6'd44
`endif

// [verilog/pin_mux_pkg.sv]
`include "pin_mux_defs.svh"
package pin_mux_pkg;
  typedef logic [`NPIN-1:0]             pin_vec_t;
  typedef logic [`NPIN-1:0][`NFN_M-1:0] m_fn_t;
  typedef logic [`NPIN-1:0][`NFN_C-1:0] c_fn_t;
  typedef logic [`NPIN-1:0][3:0]        pctl_t;
  typedef logic [`NPIN-1:0][1:0]        cmux_t;
  typedef logic [`NPIN-1:0][`QUAL_DEPTH-1:0] hist_t;
  typedef logic [`NTRIP-1:0][5:0]       trip_sel_t;
  typedef logic [`NXINT-1:0][5:0]       xint_sel_t;
endpackage

// [verilog/dual_subsystem_pin_mux.sv]
// Behaviour
// - 74 pins total; this block is the 66-pin part, 8 pins elsewhere.
// - Each pin: master peripheral, control peripheral, GPIO in or out.
// - Pins 0-63 except 39, 44 feed trips, interrupts, wake.
// - Every pin has its own independently enabled pull-up.
// - Reset: pull-ups and drivers off, every pin owned by master.
// - Pin-level selector gives each pin to master or control side.
// - Nine per-port interrupt lines go to the master controller.
// - Twelve trip lines, each from a selected pin, to control side.
// - 66 input lines; one selected line wakes the control processor.
// - All 66 inputs pass a qualifier with programmable sample period.
// - Master mux: nine register sets of eight pins, master bus.
// - Control mux: three sets up to 32 pins, control bus only.
// - Master pin picks one of 11 primary or 4 alternate signals.
// - Alternate-function stage passes at most one output to the pin.
// - Pin input returns along the same path to the chosen peripheral.
// - Control side: two bits per pin pick one of 4 signals.
// - Analog mode makes four pins USB pins, blocking digital use.
// - Pin 63 input always feeds USB PLL and both CAN clocks.
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module dual_subsystem_pin_mux (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   m_cyc_i,
  input  wire logic                   m_stb_i,
  input  wire logic                   m_we_i,
  input  wire logic [11:0]            m_adr_i,
  input  wire logic [3:0]             m_sel_i,
  input  wire logic [31:0]            m_dat_i,
  output logic      [31:0]            m_dat_o,
  output logic                        m_ack_o,
  input  wire logic                   c_cyc_i,
  input  wire logic                   c_stb_i,
  input  wire logic                   c_we_i,
  input  wire logic [11:0]            c_adr_i,
  input  wire logic [3:0]             c_sel_i,
  input  wire logic [31:0]            c_dat_i,
  output logic      [31:0]            c_dat_o,
  output logic                        c_ack_o,
  input  wire pin_mux_pkg::pin_vec_t  pad_in_i,
  output pin_mux_pkg::pin_vec_t       pad_out_o,
  output pin_mux_pkg::pin_vec_t       pad_oe_o,
  output pin_mux_pkg::pin_vec_t       pad_pullup_o,
  output logic      [3:0]             usb_analog_en_o,
  input  wire pin_mux_pkg::m_fn_t     m_fn_out_i,
  input  wire pin_mux_pkg::m_fn_t     m_fn_oe_i,
  output pin_mux_pkg::m_fn_t          m_fn_in_o,
  input  wire pin_mux_pkg::c_fn_t     c_fn_out_i,
  input  wire pin_mux_pkg::c_fn_t     c_fn_oe_i,
  output pin_mux_pkg::c_fn_t          c_fn_in_o,
  output logic      [`NSET_M-1:0]     port_irq_o,
  output logic                        irq_o,
  output logic      [`NTRIP-1:0]      trip_event_lines_o,
  output logic      [`NXINT-1:0]      ext_int_o,
  output logic                        standby_wakeup_o,
  output pin_mux_pkg::pin_vec_t       general_input_lines_o,
  output pin_mux_pkg::pin_vec_t       qualified_lines_o,
  output logic                        usb_pll_clock_input_o,
  output logic                        can0_clock_o,
  output logic                        can1_clock_o
);
  import pin_mux_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pin_vec_t  m_dat;
    pin_vec_t  m_dir;
    pin_vec_t  m_afsel;
    pin_vec_t  m_pur;
    pin_vec_t  m_apsel;
    pctl_t     m_pctl;
    pin_vec_t  m_im;
    pin_vec_t  m_ris;
    pin_vec_t  m_prev;
    logic [3:0] amsel;
    cmux_t     c_mux;
    pin_vec_t  c_claim;
    pin_vec_t  c_dir;
    pin_vec_t  c_dat;
    trip_sel_t trip_sel;
    xint_sel_t xint_sel;
    logic [5:0] wake_sel;
    logic [7:0] qper;
    logic [7:0] qcnt;
    pin_vec_t  sync1;
    pin_vec_t  sync2;
    hist_t     hist;
    pin_vec_t  qual;
    logic      m_ack;
    logic [31:0] m_rd;
    logic      c_ack;
    logic [31:0] c_rd;
    pin_vec_t  pout;
    pin_vec_t  poe;
    logic [`NSET_M-1:0] pirq;
    logic [`NTRIP-1:0]  trips;
    logic [`NXINT-1:0]  xints;
    logic      wake;
  } state_t;

  state_t st;
  state_t next_st;

  // Index of analog USB pin, or 4 when the pin is not one
  function automatic logic [2:0] usb_idx(input int p);
    case (p)
      `USB_VBUS: usb_idx = 3'd0;
      `USB_DM:   usb_idx = 3'd1;
      `USB_DP:   usb_idx = 3'd2;
      `USB_ID:   usb_idx = 3'd3;
      default:   usb_idx = 3'd4;
    endcase
  endfunction

  // Source pin allowed for trip, interrupt and wake routing
  function automatic logic src_ok(input logic [5:0] s);
    src_ok = (s != `NO_SRC_A) && (s != `NO_SRC_B);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  sel);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) merge[b*8 +: 8] = n[b*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [3:0]  ms;
    logic [3:0]  mr;
    logic [4:0]  cs;
    logic [2:0]  cr;
    logic [31:0] w;
    logic [31:0] rd;
    logic [3:0]  f;
    logic [2:0]  u;
    logic        blk;
    int          p;
    ms = m_adr_i[9:6];
    mr = m_adr_i[5:2];
    cs = {2'b00, c_adr_i[7:5]};
    cr = c_adr_i[4:2];
    w  = 32'h0;
    rd = 32'h0;
    f  = 4'h0;
    u  = 3'h0;
    blk = 1'b0;
    p  = 0;
    next_st = st;

    // Master bus read word
    for (int j = 0; j < 8; j++) begin
      p = 32'(ms) * 8 + j;
      if (p < `NPIN && ms < 4'(`NSET_M)) begin
        case (mr)
          `M_DATA:  rd[j] = st.m_dir[p] ? st.m_dat[p] : pad_in_i[p];
          `M_DIR:   rd[j] = st.m_dir[p];
          `M_AFSEL: rd[j] = st.m_afsel[p];
          `M_PUR:   rd[j] = st.m_pur[p];
          `M_PCTL:  rd[j*4 +: 4] = st.m_pctl[p];
          `M_APSEL: rd[j] = st.m_apsel[p];
          `M_IM:    rd[j] = st.m_im[p];
          `M_RIS:   rd[j] = st.m_ris[p];
          `M_MIS:   rd[j] = st.m_ris[p] & st.m_im[p];
          default:  rd[j] = 1'b0;
        endcase
      end
    end
    if (m_adr_i[9:2] == `M_AMSEL_W) rd = {28'h0, st.amsel};

    // Master events: any input edge sets a sticky status bit
    for (int i = 0; i < `NPIN; i++) begin
      next_st.m_prev[i] = pad_in_i[i];
    end

    // Master Wishbone slave: ack one cycle after request
    next_st.m_ack = m_cyc_i & m_stb_i & ~st.m_ack;
    if (m_cyc_i & m_stb_i & ~st.m_ack) next_st.m_rd = rd;
    if (m_cyc_i & m_stb_i & st.m_ack) begin
      for (int j = 0; j < 8; j++) begin
        p = 32'(ms) * 8 + j;
        if (p < `NPIN && ms < 4'(`NSET_M)) begin
          w = merge(rd, m_dat_i, m_sel_i);
          if (m_we_i) begin
            case (mr)
              `M_DATA:  next_st.m_dat[p]   = w[j];
              `M_DIR:   next_st.m_dir[p]   = w[j];
              `M_AFSEL: next_st.m_afsel[p] = w[j];
              `M_PUR:   next_st.m_pur[p]   = w[j];
              `M_PCTL:  next_st.m_pctl[p]  = w[j*4 +: 4];
              `M_APSEL: next_st.m_apsel[p] = w[j];
              `M_IM:    next_st.m_im[p]    = w[j];
              default:  ;
            endcase
          end else if (mr == `M_RIS && st.m_rd[j]) begin
            next_st.m_ris[p] = 1'b0;  // Read clears only what it reported
          end
        end
      end
      w = merge({28'h0, st.amsel}, m_dat_i, m_sel_i);
      if (m_we_i && m_adr_i[9:2] == `M_AMSEL_W) next_st.amsel = w[3:0];
    end
    // Set wins over the read clear
    for (int i = 0; i < `NPIN; i++) begin
      if (pad_in_i[i] != st.m_prev[i]) next_st.m_ris[i] = 1'b1;
    end

    // Control bus read word
    rd = 32'h0;
    if (c_adr_i[11:7] == 5'h0 && cs < 5'(`NSET_C)) begin
      for (int j = 0; j < 32; j++) begin
        p = 32'(cs) * 32 + j;
        if (p < `NPIN) begin
          case (cr)
            `C_MUX_LOW:  if (j < 16) rd[j*2 +: 2] = st.c_mux[p];
            `C_MUX_HIGH: if (j >= 16) rd[(j-16)*2 +: 2] = st.c_mux[p];
            `C_DIR:      rd[j] = st.c_dir[p];
            `C_DAT:      rd[j] = st.c_dat[p];
            `C_CLAIM:    rd[j] = st.c_claim[p];
            `C_GPI:      rd[j] = st.sync2[p];
            `C_QUAL:     rd[j] = st.qual[p];
            default:     ;
          endcase
        end
      end
    end
    for (int t = 0; t < `NTRIP; t++) begin
      if (c_adr_i[9:2] == `C_TRIP_W + 8'(t)) rd = {26'h0, st.trip_sel[t]};
    end
    for (int t = 0; t < `NXINT; t++) begin
      if (c_adr_i[9:2] == `C_XINT_W + 8'(t)) rd = {26'h0, st.xint_sel[t]};
    end
    if (c_adr_i[9:2] == `C_WAKE_W) rd = {26'h0, st.wake_sel};
    if (c_adr_i[9:2] == `C_QPER_W) rd = {24'h0, st.qper};

    // Control Wishbone slave, only path to control sets
    next_st.c_ack = c_cyc_i & c_stb_i & ~st.c_ack;
    if (c_cyc_i & c_stb_i & ~st.c_ack) next_st.c_rd = rd;
    if (c_cyc_i & c_stb_i & st.c_ack & c_we_i) begin
      w = merge(rd, c_dat_i, c_sel_i);
      if (c_adr_i[11:7] == 5'h0 && cs < 5'(`NSET_C)) begin
        for (int j = 0; j < 32; j++) begin
          p = 32'(cs) * 32 + j;
          if (p < `NPIN) begin
            case (cr)
              `C_MUX_LOW:  if (j < 16) next_st.c_mux[p] = w[j*2 +: 2];
              `C_MUX_HIGH: if (j >= 16) next_st.c_mux[p] = w[(j-16)*2 +: 2];
              `C_DIR:      next_st.c_dir[p] = w[j];
              `C_DAT:      next_st.c_dat[p] = w[j];
              `C_CLAIM:    next_st.c_claim[p] = w[j];
              default:     ;
            endcase
          end
        end
      end
      for (int t = 0; t < `NTRIP; t++) begin
        if (c_adr_i[9:2] == `C_TRIP_W + 8'(t)) next_st.trip_sel[t] = w[5:0];
      end
      for (int t = 0; t < `NXINT; t++) begin
        if (c_adr_i[9:2] == `C_XINT_W + 8'(t)) next_st.xint_sel[t] = w[5:0];
      end
      if (c_adr_i[9:2] == `C_WAKE_W) next_st.wake_sel = w[5:0];
      if (c_adr_i[9:2] == `C_QPER_W) next_st.qper = w[7:0];
    end

    // Synchroniser and qualifier on the control side
    next_st.sync1 = pad_in_i;
    next_st.sync2 = st.sync1;
    next_st.qcnt = st.qcnt + 8'h1;
    if (st.qcnt >= st.qper) begin
      next_st.qcnt = 8'h0;
      for (int i = 0; i < `NPIN; i++) begin
        next_st.hist[i] = {st.hist[i][`QUAL_DEPTH-2:0], st.sync2[i]};
        if (&next_st.hist[i]) next_st.qual[i] = 1'b1;
        if (~|next_st.hist[i]) next_st.qual[i] = 1'b0;
      end
    end

    // Pin drive: analog block, then owner, then function
    for (int i = 0; i < `NPIN; i++) begin
      u = usb_idx(i);
      blk = (u != 3'd4) && st.amsel[u[1:0]];
      f = st.m_pctl[i];
      next_st.pout[i] = 1'b0;
      next_st.poe[i]  = 1'b0;
      if (blk) begin
        next_st.poe[i] = 1'b0;
      end else if (st.c_claim[i] || st.c_mux[i] != 2'b00) begin
        if (st.c_mux[i] == 2'b00) begin
          next_st.pout[i] = st.c_dat[i];
          next_st.poe[i]  = st.c_dir[i];
        end else begin
          next_st.pout[i] = c_fn_out_i[i][st.c_mux[i] - 2'd1];
          next_st.poe[i]  = c_fn_oe_i[i][st.c_mux[i] - 2'd1];
        end
      end else if (!st.m_afsel[i]) begin
        next_st.pout[i] = st.m_dat[i];
        next_st.poe[i]  = st.m_dir[i];
      end else if (f != 4'h0 && (f <= 4'(`NPRI_M) || st.m_apsel[i])) begin
        next_st.pout[i] = m_fn_out_i[i][f - 4'h1];
        next_st.poe[i]  = m_fn_oe_i[i][f - 4'h1];
      end
    end

    // Per-port interrupts, trips, interrupts, wake
    for (int k = 0; k < `NSET_M; k++) begin
      next_st.pirq[k] = 1'b0;
      for (int j = 0; j < 8; j++) begin
        p = k * 8 + j;
        if (p < `NPIN) next_st.pirq[k] = next_st.pirq[k] | (st.m_ris[p] & st.m_im[p]);
      end
    end
    for (int t = 0; t < `NTRIP; t++) begin
      next_st.trips[t] = src_ok(st.trip_sel[t]) & st.qual[st.trip_sel[t]];
    end
    for (int t = 0; t < `NXINT; t++) begin
      next_st.xints[t] = src_ok(st.xint_sel[t]) & st.qual[st.xint_sel[t]];
    end
    next_st.wake = src_ok(st.wake_sel) & st.sync2[st.wake_sel];

    // Reset: everything to master, drivers and pull-ups off
    if (rst_i) begin
      next_st = '0;
    end else if (!ce_i) begin
      next_st = st;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // ----------------------------------------
  // Input return path
  // ----------------------------------------
  always_comb begin
    logic [2:0] u;
    logic       blk;
    logic [3:0] f;
    u = 3'h0;
    blk = 1'b0;
    f = 4'h0;
    m_fn_in_o = '0;
    c_fn_in_o = '0;
    for (int i = 0; i < `NPIN; i++) begin
      u = usb_idx(i);
      blk = (u != 3'd4) && st.amsel[u[1:0]];
      f = st.m_pctl[i];
      if (!blk && st.c_mux[i] != 2'b00) begin
        c_fn_in_o[i][st.c_mux[i] - 2'd1] = st.qual[i];
      end else if (!blk && !st.c_claim[i] && st.m_afsel[i] && f != 4'h0
                   && (f <= 4'(`NPRI_M) || st.m_apsel[i])) begin
        m_fn_in_o[i][f - 4'h1] = pad_in_i[i];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign m_dat_o               = st.m_rd;
  assign m_ack_o               = st.m_ack;
  assign c_dat_o               = st.c_rd;
  assign c_ack_o               = st.c_ack;
  assign pad_out_o             = st.pout;
  assign pad_oe_o              = st.poe;
  assign pad_pullup_o          = st.m_pur;
  assign usb_analog_en_o       = st.amsel;
  assign port_irq_o            = st.pirq;
  assign irq_o                 = |st.pirq;
  assign trip_event_lines_o    = st.trips;
  assign ext_int_o             = st.xints;
  assign standby_wakeup_o      = st.wake;
  assign general_input_lines_o = st.sync2;
  assign qualified_lines_o     = st.qual;
  // Clock pin passes through regardless of muxing
  assign usb_pll_clock_input_o = pad_in_i[`AUX_CLK_PIN];
  assign can0_clock_o          = pad_in_i[`AUX_CLK_PIN];
  assign can1_clock_o          = pad_in_i[`AUX_CLK_PIN];
endmodule // dual_subsystem_pin_mux

// [verif/pin_mux_properties.sv]
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
// ----------------------------------------
// Port-level checks of the pin mux
// ----------------------------------------
module pin_mux_properties (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  input wire logic                  m_cyc_i,
  input wire logic                  m_stb_i,
  input wire logic                  m_ack_o,
  input wire logic                  c_cyc_i,
  input wire logic                  c_stb_i,
  input wire logic                  c_ack_o,
  input wire pin_mux_pkg::pin_vec_t pad_in_i,
  input wire pin_mux_pkg::pin_vec_t pad_oe_o,
  input wire pin_mux_pkg::pin_vec_t pad_pullup_o,
  input wire logic [3:0]            usb_analog_en_o,
  input wire logic [`NSET_M-1:0]    port_irq_o,
  input wire logic                  irq_o,
  input wire pin_mux_pkg::pin_vec_t general_input_lines_o,
  input wire logic                  usb_pll_clock_input_o,
  input wire logic                  can0_clock_o,
  input wire logic                  can1_clock_o
);
  import pin_mux_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Each bus answers a taken request next cycle, with a single pulse
  a_m_ack_next: assert property (m_cyc_i && m_stb_i && !m_ack_o && ce_i |=> m_ack_o)
    else $error("master request not acked next cycle");
  a_m_ack_pulse: assert property (m_ack_o && ce_i |=> !m_ack_o)
    else $error("master ack longer than one cycle");
  a_c_ack_next: assert property (c_cyc_i && c_stb_i && !c_ack_o && ce_i |=> c_ack_o)
    else $error("control request not acked next cycle");
  a_c_ack_pulse: assert property (c_ack_o && ce_i |=> !c_ack_o)
    else $error("control ack longer than one cycle");
  // Quiet pins on leaving reset
  a_reset_quiet: assert property ($fell(rst_i) |->
    pad_oe_o == '0 && pad_pullup_o == '0 && usb_analog_en_o == 4'h0)
    else $error("drivers or pull-ups active after reset");
  // Aux clock tie, interrupt merge, input sync, analog blocking
  a_aux_clock_tie: assert property (usb_pll_clock_input_o == pad_in_i[63]
    && can0_clock_o == pad_in_i[63] && can1_clock_o == pad_in_i[63])
    else $error("aux clock not tied to pin 63");
  a_irq_merge: assert property (irq_o == (|port_irq_o))
    else $error("irq not the OR of port interrupts");
  a_gpi_two_flops: assert property (!$past(rst_i) && !$past(rst_i, 2) && $past(ce_i)
    && $past(ce_i, 2) |-> general_input_lines_o == $past(pad_in_i, 2))
    else $error("input lines not two-flop synced");
  a_usb_blocks: assert property (usb_analog_en_o[0] && $past(usb_analog_en_o[0])
    |-> !pad_oe_o[`USB_VBUS])
    else $error("analog pin still driven");
endmodule // pin_mux_properties

bind dual_subsystem_pin_mux pin_mux_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .m_cyc_i(m_cyc_i), .m_stb_i(m_stb_i),
  .m_ack_o(m_ack_o), .c_cyc_i(c_cyc_i), .c_stb_i(c_stb_i), .c_ack_o(c_ack_o),
  .pad_in_i(pad_in_i), .pad_oe_o(pad_oe_o), .pad_pullup_o(pad_pullup_o),
  .usb_analog_en_o(usb_analog_en_o), .port_irq_o(port_irq_o), .irq_o(irq_o),
  .general_input_lines_o(general_input_lines_o),
  .usb_pll_clock_input_o(usb_pll_clock_input_o), .can0_clock_o(can0_clock_o),
  .can1_clock_o(can1_clock_o)
);

// [verif/pin_mux_peripherals.sv]
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
// ----------------------------------------
// Peripherals of both subsystems
// ----------------------------------------
module pin_mux_peripherals (
  input  wire logic          lvl_i,
  output pin_mux_pkg::m_fn_t m_out_o,
  output pin_mux_pkg::m_fn_t m_oe_o,
  output pin_mux_pkg::c_fn_t c_out_o,
  output pin_mux_pkg::c_fn_t c_oe_o
);
  import pin_mux_pkg::*;
  // Odd functions drive the inverse level, so a wrong pick shows at the pin
  always_comb begin
    for (int p = 0; p < `NPIN; p++) begin
      for (int f = 0; f < `NFN_M; f++) m_out_o[p][f] = lvl_i ^ f[0];
      for (int f = 0; f < `NFN_C; f++) c_out_o[p][f] = lvl_i ^ f[0];
    end
  end
  // Every peripheral always wants its pin
  assign m_oe_o = '1;
  assign c_oe_o = '1;
endmodule // pin_mux_peripherals

// [verif/dual_subsystem_pin_mux_tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module dual_subsystem_pin_mux_tb_top;
  import pin_mux_pkg::*;
  typedef struct packed {logic cyc, stb, we; logic [11:0] adr; logic [31:0] dat;} wb_req_t;
  wb_req_t     rq [2] = '{default: '0};
  logic [1:0]  ack;
  logic [31:0] rd [2];
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        lvl = 1'b1;
  logic        ce = 1'b1;
  pin_vec_t    pad_in = '0;
  pin_vec_t    pad_out, pad_oe, pad_pu, gpi, qual;
  m_fn_t       m_out, m_oe, m_in;
  c_fn_t       c_out, c_oe, c_in;
  logic [8:0]  pirq;
  logic [11:0] trip;
  logic [3:0]  usb_en;
  logic [2:0]  xint, aux;
  logic        irq, wake;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  dual_subsystem_pin_mux dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .m_sel_i(4'hf), .c_sel_i(4'hf),
    .m_cyc_i(rq[0].cyc), .m_stb_i(rq[0].stb), .m_we_i(rq[0].we), .m_adr_i(rq[0].adr),
    .m_dat_i(rq[0].dat), .m_dat_o(rd[0]), .m_ack_o(ack[0]),
    .c_cyc_i(rq[1].cyc), .c_stb_i(rq[1].stb), .c_we_i(rq[1].we), .c_adr_i(rq[1].adr),
    .c_dat_i(rq[1].dat), .c_dat_o(rd[1]), .c_ack_o(ack[1]),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu),
    .usb_analog_en_o(usb_en), .m_fn_out_i(m_out), .m_fn_oe_i(m_oe), .m_fn_in_o(m_in),
    .c_fn_out_i(c_out), .c_fn_oe_i(c_oe), .c_fn_in_o(c_in), .port_irq_o(pirq),
    .irq_o(irq), .trip_event_lines_o(trip), .ext_int_o(xint), .standby_wakeup_o(wake),
    .general_input_lines_o(gpi), .qualified_lines_o(qual),
    .usb_pll_clock_input_o(aux[0]), .can0_clock_o(aux[1]), .can1_clock_o(aux[2])
  );
  pin_mux_peripherals periph (.lvl_i(lvl), .m_out_o(m_out), .m_oe_o(m_oe),
    .c_out_o(c_out), .c_oe_o(c_oe));
  // Compare and count
  task automatic chk(input string what, input logic [65:0] exp, input logic [65:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic cycle; d is write data, or expected read data
  task automatic wb(input int b, input logic we, input logic [7:0] w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    rq[b] <= '{1'b1, 1'b1, we, {2'b00, w, 2'b00}, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack[b] !== 1'b1 && n < 20);
    chk("ack", 1, ack[b]);
    if (!we) chk("read data", d, rd[b]);
    rq[b] <= '0;
  endtask
  task automatic after(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pin(input int p, input logic v);
    @(posedge clk_i);
    pad_in[p] <= v;
  endtask
  task automatic t_static;
    after(1);
    chk("reset oe", 0, pad_oe);
    chk("reset pullup", 0, pad_pu);
    wb(0, 0, 8'h01, 0);
    wb(0, 0, 8'h8f, 0);
    wb(1, 0, 8'h3f, 0);
    pin(8, 1);
    wb(0, 1, 8'h11, 32'hf0);
    wb(0, 1, 8'h10, 32'haf);
    wb(0, 1, 8'h23, 32'h5a);
    wb(0, 1, 8'h83, 32'h3);
    after(2);
    chk("gpio oe", 66'hf000, pad_oe);
    chk("gpio out", 66'ha000, pad_out & pad_oe);
    chk("pullups", (66'h3 << 64) | (66'h5a << 16), pad_pu);
    wb(0, 0, 8'h10, 32'ha1);
    $display("test static done");
  endtask
  task automatic t_irq;
    wb(0, 1, 8'h06, 32'h8);
    pin(4, 1);
    after(6);
    chk("masked irq", 0, irq);
    pin(3, 1);
    after(6);
    chk("port irq", 9'h1, pirq);
    wb(0, 0, 8'h08, 32'h8);
    wb(0, 0, 8'h07, 32'h18);
    after(2);
    chk("irq cleared", 0, irq);
    wb(0, 0, 8'h07, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_select;
    wb(0, 1, 8'h02, 32'h2);
    wb(0, 1, 8'h04, 32'he0);
    after(3);
    chk("alt without apsel", 0, pad_oe[1]);
    wb(0, 1, 8'h05, 32'h2);
    for (int c = 1; c < 16; c++) begin
      wb(0, 1, 8'h04, 32'(c) << 4);
      after(3);
      chk("fn oe", 1, pad_oe[1]);
      chk("fn out", c[0], pad_out[1]);
    end
    for (int v = 1; v >= 0; v--) begin
      pin(1, v[0]);
      after(1);
      chk("fn in", v[0], m_in[1][14]);
    end
    for (int m = 1; m < 4; m++) begin
      wb(1, 1, 8'h08, 32'(m) << 4);
      after(3);
      chk("ctl oe", 1, pad_oe[34]);
      chk("ctl out", m[0], pad_out[34]);
    end
    chk("master pin kept", 1, pad_oe[1]);
    wb(1, 1, 8'h0a, 32'h100);
    wb(1, 1, 8'h0b, 32'h100);
    wb(1, 1, 8'h0c, 32'h100);
    after(3);
    chk("ctl gpio", 2'b11, {pad_oe[40], pad_out[40]});
    wb(1, 0, 8'h0c, 32'h100);
    $display("test select done");
  endtask
  task automatic t_events;
    wb(1, 1, 8'h20, 32'd5);
    wb(1, 1, 8'h21, 32'd39);
    wb(1, 1, 8'h2c, 32'd6);
    wb(1, 1, 8'h2f, 32'd5);
    @(posedge clk_i);
    pad_in <= pad_in | (66'h1 << 5) | (66'h1 << 39);
    after(4);
    chk("wake", 1, wake);
    chk("trip early", 0, trip[0]);
    after(8);
    chk("trips", 12'h1, trip);
    chk("gpi", 1, gpi[5]);
    pin(6, 1);
    after(2);
    pin(6, 0);
    after(10);
    chk("short pulse", 0, xint);
    wb(1, 1, 8'h30, 32'h3);
    pin(7, 1);
    pin(34, 1);
    after(12);
    chk("slow qual early", 0, qual[7]);
    after(28);
    chk("slow qual", 1, qual[7]);
    chk("ctl fn in", 1, c_in[34][2]);
    $display("test events done");
  endtask
  task automatic t_analog;
    wb(0, 1, 8'h41, 32'h40);
    wb(0, 1, 8'h90, 32'hf);
    after(3);
    chk("usb mode", 4'hf, usb_en);
    chk("usb pin blocked", 0, pad_oe[38]);
    pin(63, 1);
    after(1);
    chk("aux clock", 3'b111, aux);
    @(posedge clk_i);
    ce <= 1'b0;
    pad_in[9] <= 1'b1;
    after(4);
    chk("frozen gpi", 0, gpi[9]);
    @(posedge clk_i);
    ce <= 1'b1;
    after(3);
    chk("thawed gpi", 1, gpi[9]);
    $display("test analog done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_static();
    t_irq();
    t_select();
    t_events();
    t_analog();
    give_verdict();
  end
endmodule // dual_subsystem_pin_mux_tb_top
